//--- core/tdp_consts.vh
// constants for the two-wire debug register port
`ifndef TDP_CONSTS_VH
`define TDP_CONSTS_VH
`define TDP_SEL_PART_ID      8'h00
`define TDP_SEL_REVISION     8'h01
`define TDP_SEL_PROG_CTL     8'h02
`define TDP_SEL_PROG_DATA    8'hAD
`define TDP_UNLOCK_FIRST     8'h02
`define TDP_UNLOCK_SECOND    8'h01
`define TDP_CMD_BLOCK_READ   8'h06
`define TDP_CMD_BLOCK_WRITE  8'h07
`define TDP_CMD_PAGE_ERASE   8'h08
`define TDP_CMD_DEVICE_ERASE 8'h03
`define TDP_RESET_BYTE       8'h00
`define TDP_INS_DATA_READ    2'b00
`define TDP_INS_ADDR_WRITE   2'b01
`define TDP_INS_ADDR_READ    2'b10
`define TDP_INS_DATA_WRITE   2'b11
`define TDP_ST_IDLE          3'd0
`define TDP_ST_INS           3'd1
`define TDP_ST_WDATA         3'd2
`define TDP_ST_WAIT          3'd3
`define TDP_ST_RDATA         3'd4
`define TDP_ST_STOP          3'd5
`define TDP_RESET_LOW_SAMPLES 10'd500
`define TDP_LAST_BIT         4'h7
`endif

//--- core/tdp_port.v
// target register set and frame engine of the two-wire debug port
`include "tdp_consts.vh"
`default_nettype none
// Summary of operation
// - host clock line plus one bidirectional data line
// - registers reachable only over the link
// - select register steers data read/write target
// - select zero reads part identity
// - select 0x01 reads silicon revision
// - select 0x02 reaches programming control register
// - select 0xAD reaches programming data register
// - part identity is fixed read-only byte
// - silicon revision is read-only revision byte
// - write 0x02 then 0x01 enables programming
// - enabled programming holds until system reset
// - data register carries flash commands and data
module tdp_port #(
  parameter [7:0] PART_ID  = 8'h5A, // arbitrary value
  parameter [7:0] REV_ID   = 8'h11, // arbitrary value
  parameter [9:0] RST_LOW  = `TDP_RESET_LOW_SAMPLES
) (
  input  wire       clock_i,
  input  wire       reset_n_i,
  input  wire       debug_link_clock_i,
  input  wire       debug_link_data_i,
  output reg        debug_link_data_o,
  output reg        debug_link_data_oe_o,
  output reg        prog_enabled_o,
  output reg        halt_normal_o,
  output reg        system_reset_o,
  output reg  [7:0] flash_cmd_o,
  output reg        flash_cmd_valid_o,
  output reg  [7:0] link_register_select_o
);
  wire       ck_s;
  wire       d_s;
  reg        ck_q_r;
  reg  [2:0] state_r;
  reg  [1:0] ins_r;
  reg  [3:0] cnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] flash_program_control_r;
  reg  [7:0] flash_program_data_r;
  reg        unlock_half_r;
  reg  [9:0] low_cnt_r;
  reg  [7:0] rd_byte;
  wire       rise;
  wire       fall;

  // link clock sampled as a plain input
  tdp_sync u_sync_ck (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .pin_i     (debug_link_clock_i),
    .level_o   (ck_s)
  );
  tdp_sync u_sync_d (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .pin_i     (debug_link_data_i),
    .level_o   (d_s)
  );

  assign rise = ck_s & ~ck_q_r;
  assign fall = ~ck_s & ck_q_r;

  // read mux steered by the select register
  always @* begin
    case (link_register_select_o)
      `TDP_SEL_PART_ID:   rd_byte = PART_ID;
      `TDP_SEL_REVISION:  rd_byte = REV_ID;
      `TDP_SEL_PROG_CTL:  rd_byte = flash_program_control_r;
      `TDP_SEL_PROG_DATA: rd_byte = flash_program_data_r;
      default:            rd_byte = `TDP_RESET_BYTE;
    endcase
  end

  // frame engine: start, 2-bit instruction, one byte, stop; lsb first.
  // data is sampled on rising edges, driven after falling edges. the registers
  // live only here, no processor bus reaches them
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      ck_q_r                  <= 1'b1;
      state_r                 <= `TDP_ST_IDLE;
      ins_r                   <= 2'b00;
      cnt_r                   <= 4'd0;
      shift_r                 <= `TDP_RESET_BYTE;
      flash_program_control_r <= `TDP_RESET_BYTE;
      flash_program_data_r    <= `TDP_RESET_BYTE;
      unlock_half_r           <= 1'b0;
      low_cnt_r               <= 10'd0;
      debug_link_data_o       <= 1'b0;
      debug_link_data_oe_o    <= 1'b0;
      prog_enabled_o          <= 1'b0;
      halt_normal_o           <= 1'b0;
      system_reset_o          <= 1'b0;
      flash_cmd_o             <= `TDP_RESET_BYTE;
      flash_cmd_valid_o       <= 1'b0;
      link_register_select_o  <= `TDP_SEL_PART_ID;
    end else begin
      ck_q_r            <= ck_s;
      flash_cmd_valid_o <= 1'b0;
      system_reset_o    <= 1'b0;
      // a long low on the clock line is the host's system reset
      if (ck_s) begin
        low_cnt_r <= 10'd0;
      end else if (low_cnt_r != RST_LOW) begin
        low_cnt_r <= low_cnt_r + 10'd1;
        if (low_cnt_r + 10'd1 == RST_LOW) begin
          system_reset_o          <= 1'b1;
          prog_enabled_o          <= 1'b0;
          halt_normal_o           <= 1'b0;
          unlock_half_r           <= 1'b0;
          flash_program_control_r <= `TDP_RESET_BYTE;
          link_register_select_o  <= `TDP_SEL_PART_ID;
          state_r                 <= `TDP_ST_IDLE;
          debug_link_data_oe_o    <= 1'b0;
        end
      end
      // the rise that ends a reset low is not a start bit, or frames slip
      if (rise && low_cnt_r != RST_LOW) begin
        case (state_r)
          `TDP_ST_IDLE: begin
            state_r <= `TDP_ST_INS;
            cnt_r   <= 4'd0;
          end
          `TDP_ST_INS: begin
            ins_r[cnt_r[0]] <= d_s;
            cnt_r           <= cnt_r + 4'd1;
            if (cnt_r[0]) begin
              cnt_r <= 4'd0;
              if ({d_s, ins_r[0]} == `TDP_INS_ADDR_WRITE ||
                  {d_s, ins_r[0]} == `TDP_INS_DATA_WRITE) begin
                state_r <= `TDP_ST_WDATA;
              end else begin
                state_r <= `TDP_ST_RDATA;
                shift_r <= ({d_s, ins_r[0]} == `TDP_INS_ADDR_READ) ?
                           link_register_select_o : rd_byte;
              end
            end
          end
          `TDP_ST_WDATA: begin
            shift_r <= {d_s, shift_r[7:1]};
            cnt_r   <= cnt_r + 4'd1;
            if (cnt_r == `TDP_LAST_BIT) begin
              state_r <= `TDP_ST_STOP;
              if (ins_r == `TDP_INS_ADDR_WRITE) begin
                link_register_select_o <= {d_s, shift_r[7:1]};
              end else begin
                case (link_register_select_o)
                  `TDP_SEL_PROG_CTL: begin
                    flash_program_control_r <= {d_s, shift_r[7:1]};
                    // two then one, back to back, unlocks
                    unlock_half_r <= ({d_s, shift_r[7:1]} == `TDP_UNLOCK_FIRST);
                    if (unlock_half_r &&
                        {d_s, shift_r[7:1]} == `TDP_UNLOCK_SECOND) begin
                      prog_enabled_o <= 1'b1;
                      halt_normal_o  <= 1'b1;
                    end
                  end
                  `TDP_SEL_PROG_DATA: begin
                    flash_program_data_r <= {d_s, shift_r[7:1]};
                    // commands only reach flash once unlocked
                    if (prog_enabled_o) begin
                      flash_cmd_o       <= {d_s, shift_r[7:1]};
                      flash_cmd_valid_o <= 1'b1;
                    end
                  end
                  default: begin
                    // identity registers ignore writes
                    unlock_half_r <= unlock_half_r;
                  end
                endcase
              end
            end
          end
          `TDP_ST_RDATA: begin
            cnt_r <= cnt_r + 4'd1;
            if (cnt_r == `TDP_LAST_BIT) begin
              state_r <= `TDP_ST_STOP;
            end
          end
          `TDP_ST_STOP: begin
            state_r <= `TDP_ST_IDLE;
          end
          default: state_r <= `TDP_ST_IDLE;
        endcase
      end
      // drive read bits after the falling edge; release at stop
      if (fall) begin
        if (state_r == `TDP_ST_RDATA) begin
          debug_link_data_oe_o <= 1'b1;
          debug_link_data_o    <= shift_r[0];
          shift_r              <= {1'b0, shift_r[7:1]};
        end else begin
          debug_link_data_oe_o <= 1'b0;
        end
      end
    end
  end
endmodule // tdp_port
`default_nettype wire

//--- core/tdp_sync.v
// two-flop synchroniser for one pin level
`default_nettype none
module tdp_sync (
  input  wire clock_i,
  input  wire reset_n_i,
  input  wire pin_i,
  output reg  level_o
);
  reg meta_r;
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      meta_r  <= 1'b1;
      level_o <= 1'b1;
    end else begin
      meta_r  <= pin_i;
      level_o <= meta_r;
    end
  end
endmodule // tdp_sync
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the debug register port
`include "tdp_consts.vh"
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PID = 8'h3C; // arbitrary value
  localparam logic [7:0] RID = 8'h4B; // arbitrary value
  localparam logic [7:0] CODES [4] = '{`TDP_CMD_BLOCK_READ, `TDP_CMD_BLOCK_WRITE,
    `TDP_CMD_PAGE_ERASE, `TDP_CMD_DEVICE_ERASE};
  logic       clock_i;
  logic       reset_n_i;
  logic       lclk;
  logic       dwire;
  logic       d_o;
  logic       oe;
  logic       pe;
  logic       halt;
  logic       srst;
  logic [7:0] cmd;
  logic       cmdv;
  logic [7:0] sel_o;
  logic [7:0] r;
  int         fails = 0;
  int         checks_done = 0;
  int         cmds = 0;
  int         srsts = 0;
  tdp_host_model host_i (.clock_i(clock_i), .dev_d_i(d_o), .dev_oe_i(oe), .link_clk_o(lclk),
    .wire_o(dwire));
  tdp_port #(.PART_ID(PID), .REV_ID(RID), .RST_LOW(10'd20)) tdp_port_i (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .debug_link_clock_i(lclk), .debug_link_data_i(dwire),
    .debug_link_data_o(d_o), .debug_link_data_oe_o(oe), .prog_enabled_o(pe),
    .halt_normal_o(halt), .system_reset_o(srst), .flash_cmd_o(cmd), .flash_cmd_valid_o(cmdv),
    .link_register_select_o(sel_o));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (cmdv === 1'b1) cmds++;
    if (srst === 1'b1) srsts++;
  end
  task automatic sel(input logic [7:0] a);
    host_i.frame(`TDP_INS_ADDR_WRITE, a, r);
  endtask
  task automatic dw(input logic [7:0] v);
    host_i.frame(`TDP_INS_DATA_WRITE, v, r);
  endtask
  task automatic dr(input string n, input logic [7:0] e);
    host_i.frame(`TDP_INS_DATA_READ, 8'h00, r);
    `CHK(n, e, r)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock_i);
    fails++;
    tally_and_finish;
  end
  initial begin
    reset_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("select", `TDP_SEL_PART_ID, sel_o)
    dr("part_id", PID);
    dw(8'h77);
    dr("part_id_kept", PID);
    sel(`TDP_SEL_REVISION);
    host_i.frame(`TDP_INS_ADDR_READ, 8'h00, r);
    `CHK("select_read", `TDP_SEL_REVISION, r)
    dr("revision", RID);
    dw(8'h00);
    dr("revision_kept", RID);
    sel(8'h55);
    dr("unmapped", 8'h00);
    $display("identity test done");
    sel(`TDP_SEL_PROG_DATA);
    dw(`TDP_CMD_BLOCK_READ);
    `CHK("locked_cmds", 0, cmds)
    sel(`TDP_SEL_PROG_CTL);
    dw(`TDP_UNLOCK_SECOND);
    dw(`TDP_UNLOCK_FIRST);
    `CHK("early_enable", 1'b0, pe)
    dw(`TDP_UNLOCK_SECOND);
    `CHK("enabled", 1'b1, pe)
    `CHK("halted", 1'b1, halt)
    dr("prog_ctl", `TDP_UNLOCK_SECOND);
    $display("unlock test done");
    sel(`TDP_SEL_PROG_DATA);
    for (int i = 0; i < 4; i++) begin
      dw(CODES[i]);
      `CHK("cmd", CODES[i], cmd)
    end
    `CHK("cmd_count", 4, cmds)
    dr("prog_data", `TDP_CMD_DEVICE_ERASE);
    $display("command test done");
    host_i.hold_low(40);
    `CHK("sys_resets", 1, srsts)
    `CHK("halt_after", 1'b0, halt)
    `CHK("locked_after", 1'b0, pe)
    `CHK("select_after", `TDP_SEL_PART_ID, sel_o)
    dr("part_id_after", PID);
    $display("reset test done");
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire

//--- sim/tdp_host_model.sv
// host adapter model: drives link clock and shares the data line
`default_nettype none
module tdp_host_model (
  input  wire logic clock_i,
  input  wire logic dev_d_i,
  input  wire logic dev_oe_i,
  output var  logic link_clk_o,
  output wire logic wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hd = 1'b1;
  logic hoe = 1'b1;
  logic idle_r = 1'b0;
  logic smp;
  initial link_clk_o = 1'b1;
  // released line toggles so a stale level never looks valid
  assign wire_o = dev_oe_i ? dev_d_i : (hoe ? hd : idle_r);
  always @(posedge clock_i) begin
    idle_r <= ~idle_r;
  end
  task automatic pulse(input logic b, input logic drv);
    link_clk_o <= 1'b0;
    hoe        <= drv;
    hd         <= b;
    repeat (8) @(posedge clock_i);
    smp = wire_o;
    link_clk_o <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
  // on reads the line stays released through stop, so the device can let go
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    pulse(1'b1, 1'b1);
    pulse(ins[0], 1'b1);
    pulse(ins[1], 1'b1);
    for (int i = 0; i < 8; i++) begin
      pulse(wd[i], ins[0]);
      rd[i] = smp;
    end
    pulse(1'b1, ins[0]);
  endtask
  task automatic hold_low(input int n);
    link_clk_o <= 1'b0;
    repeat (n) @(posedge clock_i);
    link_clk_o <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
endmodule // tdp_host_model
`default_nettype wire

//--- sim/tdp_port_asserts.sv
// pin-level checks on the debug register port
`default_nettype none
module tdp_port_asserts (
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic       debug_link_clock_i,
  input wire logic       debug_link_data_oe_o,
  input wire logic       prog_enabled_o,
  input wire logic       halt_normal_o,
  input wire logic       system_reset_o,
  input wire logic       flash_cmd_valid_o,
  input wire logic [7:0] link_register_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  chk_halt_follows: assert property ($rose(prog_enabled_o) |-> ##[0:1] halt_normal_o)
    else $error("halt missing after unlock");
  chk_cmd_locked: assert property (flash_cmd_valid_o |-> prog_enabled_o)
    else $error("flash command while locked");
  chk_cmd_pulse: assert property (flash_cmd_valid_o |=> !flash_cmd_valid_o)
    else $error("command strobe too long");
  chk_enable_hold: assert property ($fell(prog_enabled_o) |-> system_reset_o)
    else $error("unlock lost without reset");
  chk_halt_hold: assert property ($fell(halt_normal_o) |-> system_reset_o)
    else $error("halt dropped without reset");
  chk_reset_cause: assert property (system_reset_o |-> !$past(debug_link_clock_i, 8))
    else $error("reset without long low clock");
  chk_select_quiet: assert property (!$stable(link_register_select_o) |->
    !debug_link_data_oe_o)
    else $error("select moved while driving");
  chk_drive_on_low: assert property ($rose(debug_link_data_oe_o) |->
    !$past(debug_link_clock_i))
    else $error("drive began on high clock");
  cover property (flash_cmd_valid_o);
  cover property (system_reset_o);
  cover property ($rose(debug_link_data_oe_o));
endmodule // tdp_port_asserts
bind tdp_port tdp_port_asserts tdp_port_asserts_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .debug_link_clock_i(debug_link_clock_i), .debug_link_data_oe_o(debug_link_data_oe_o),
  .prog_enabled_o(prog_enabled_o), .halt_normal_o(halt_normal_o),
  .system_reset_o(system_reset_o), .flash_cmd_valid_o(flash_cmd_valid_o),
  .link_register_select_o(link_register_select_o));
`default_nettype wire
